// File: inc/mtxfg_pkg.sv
// Shared constants, types and register map of the transmit framer and replay guard.
package mtxfg_pkg;
  localparam logic [7:0] API_DELIM = 8'h7e;
  localparam logic [7:0] CSUM_BASE = 8'hff;
  localparam logic [7:0] TYPE_TXREQ = 8'h10;
  localparam logic [7:0] TYPE_LCMD = 8'h08;
  localparam logic [7:0] TYPE_TXSTAT = 8'h8b;
  localparam logic [7:0] TYPE_RX = 8'h90;
  localparam logic [7:0] TYPE_RXEXP = 8'h91;
  localparam logic [15:0] ADDR16_UNK = 16'hfffe;
  localparam logic [63:0] ADDR64_COORD = 64'h0000_0000_0000_0000;
  localparam logic [63:0] ADDR64_BCAST = 64'h0000_0000_0000_ffff;
  localparam logic [7:0] NWK_MAX_RADIUS = 8'h1e;
  localparam logic [7:0] NH_RST = 8'h1e;
  localparam logic [15:0] SP_RST = 16'h0020;
  localparam logic [31:0] FCNT_MAX = 32'hffff_ffff;
  localparam logic [1:0] MAX_ATTEMPTS = 2'h3;
  localparam int HOP_MS_MULT = 50;
  localparam int UNI_BASE_MS = 100;
  localparam int SP_UNIT_MS = 10;
  localparam int HOLD_NUM = 12;
  localparam int HOLD_DEN = 10;
  localparam int CLK_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS_DOC = (MS_NS + CLK_NS - 1) / CLK_NS;
  localparam int B_TYPE = 0;
  localparam int B_FID = 1;
  localparam int B_D64 = 2;
  localparam int B_D16 = 10;
  localparam int B_RAD = 12;
  localparam int B_OPT = 13;
  localparam int B_CMD = 2;
  localparam int B_PARAM = 4;
  localparam logic [15:0] TXREQ_MIN_LEN = 16'h000e;
  localparam logic [15:0] LCMD_MIN_LEN = 16'h0005;
  localparam logic [15:0] SP_CMD_LEN = 16'h0006;
  localparam int OPT_EXT_BIT = 6;
  localparam logic [15:0] CMD_AO = 16'h414f;
  localparam logic [15:0] CMD_NH = 16'h4e48;
  localparam logic [15:0] CMD_SP = 16'h5350;
  localparam logic [7:0] STAT_LEN_L = 8'h03;
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_NOACK = 8'h01;
  localparam logic [7:0] ST_BLOCKED = 8'h02;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_HOPS = 5'h04;
  localparam logic [4:0] REG_SLEEP = 5'h08;
  localparam logic [4:0] REG_FCNT = 5'h0c;
  localparam logic [4:0] REG_STAT = 5'h10;
  localparam int CTRL_SEC_BIT = 0;
  localparam int CTRL_AO_BIT = 1;
  localparam int CTRL_KEY_BIT = 2;
  typedef enum logic [4:0] {
    P_IDLE = 5'b00001, P_LENH = 5'b00010, P_LENL = 5'b00100,
    P_BODY = 5'b01000, P_CSUM = 5'b10000
  } mtxfg_pstate_e;
  typedef enum logic [3:0] {
    T_IDLE = 4'b0001, T_SEND = 4'b0010, T_WAIT = 4'b0100, T_REPORT = 4'b1000
  } mtxfg_tstate_e;
  typedef struct packed {
    logic [63:0] dst64;
    logic [15:0] dst16;
    logic [7:0] radius;
    logic secure;
    logic to_coord;
    logic bcast;
    logic wake_sleepers;
  } mtxfg_rfreq_s;
endpackage

// File: rtl/mtxfg_top.sv
// Host API transmit framer with retry timing, frame counter and replay guard.
//
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
module mtxfg_top
  import mtxfg_pkg::*;
#(
  parameter int CYC_PER_MS = CYC_PER_MS_DOC,
  parameter int MAXB = 32,
  parameter int NBR = 8
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic [4:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire logic I_API_RX_VALID,
  input wire logic [7:0] I_API_RX_DATA,
  input wire logic I_API_RX_LAST,
  output logic O_API_TX_VALID,
  output logic [7:0] O_API_TX_DATA,
  input wire logic I_API_TX_READY,
  input wire logic I_DST_END_DEV,
  output logic O_RF_SEND,
  output mtxfg_rfreq_s O_RF_REQ,
  output logic [31:0] O_RF_FCNT,
  input wire logic I_RF_ACK,
  input wire logic I_MAC_BEACON_REQ,
  output logic O_MAC_BEACON_SEND,
  input wire logic I_RF_RX_VALID,
  input wire logic I_RF_RX_PROFILE,
  input wire logic I_RF_RX_SECURED,
  input wire logic I_RF_RX_MIC_OK,
  input wire logic [$clog2(NBR)-1:0] I_RF_RX_NBR,
  input wire logic [31:0] I_RF_RX_FCNT,
  output logic O_RX_DELIVER,
  output logic O_RX_DROP,
  output logic [7:0] O_RX_FRAME_TYPE,
  input wire logic I_CHILD_HOLD_START,
  input wire logic I_CHILD_POLLED,
  output logic O_CHILD_DISCARD
);
  localparam int IW = $clog2(MAXB);

  function automatic logic [19:0] tmo_ms(input logic [7:0] nh, input logic [15:0] sp,
                                         input logic ext);
    int t;
    t = HOP_MS_MULT * int'(nh);
    if (ext) t = t + (int'(sp) * SP_UNIT_MS * HOLD_NUM) / HOLD_DEN;
    else t = t + UNI_BASE_MS;
    return t[19:0];
  endfunction

  function automatic logic [19:0] hold_ms(input logic [15:0] sp);
    int t;
    t = (int'(sp) * SP_UNIT_MS * HOLD_NUM) / HOLD_DEN;
    return t[19:0];
  endfunction

  function automatic logic [7:0] stat_byte(input logic [2:0] idx, input logic [7:0] fid,
                                           input logic [7:0] st);
    logic [7:0] b;
    unique case (idx)
      3'h0: b = API_DELIM;
      3'h1: b = 8'h00;
      3'h2: b = STAT_LEN_L;
      3'h3: b = TYPE_TXSTAT;
      3'h4: b = fid;
      3'h5: b = st;
      default: b = CSUM_BASE - 8'(TYPE_TXSTAT + fid + st);
    endcase
    return b;
  endfunction

  logic ack_r;
  logic [31:0] rdata_r;
  logic sec_en_r;
  logic ao_r;
  logic key_new_r;
  logic [7:0] nh_r;
  logic [15:0] sp_r;
  logic [31:0] fcnt_r;
  logic [7:0] rej_r;
  mtxfg_pstate_e p_st_r;
  logic [15:0] len_r;
  logic [15:0] cnt_r;
  logic [7:0] sum_r;
  logic frame_ok_r;
  logic frame_bad_r;
  logic [7:0] body [MAXB];
  mtxfg_tstate_e t_st_r;
  mtxfg_rfreq_s rfreq_r;
  logic ext_r;
  logic [7:0] fid_r;
  logic [7:0] tx_stat_r;
  logic [1:0] attempt_r;
  logic send_r;
  logic [19:0] tmo_r;
  logic [$clog2(CYC_PER_MS)-1:0] presc_r;
  logic tick;
  logic ser_busy_r;
  logic [2:0] ser_idx_r;
  logic [7:0] ser_byte_r;
  logic [31:0] nbr_cnt [NBR];
  logic rx_stale;
  logic rx_ok;
  logic deliver_r;
  logic drop_r;
  logic [7:0] rx_type_r;
  logic hold_act_r;
  logic [19:0] hold_r;
  logic discard_r;
  logic beacon_r;
  logic blocked;
  logic wr_acc;
  logic [63:0] d64;
  logic [15:0] d16;
  logic [15:0] cmd;
  logic start_tx;
  logic lcmd_ok;

  assign wr_acc = I_AVS_WRITE && ack_r;
  assign O_AVS_WAITREQUEST = (I_AVS_READ || I_AVS_WRITE) && !ack_r;
  assign O_AVS_READDATA = rdata_r;

  // Every access is answered on its second cycle.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) ack_r <= 1'b0;
    else ack_r <= (I_AVS_READ || I_AVS_WRITE) && !ack_r;
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      rdata_r <= 32'h0000_0000;
    end else if (I_AVS_READ && !ack_r) begin
      unique case (I_AVS_ADDRESS)
        REG_CTRL: rdata_r <= {30'h0000_0000, ao_r, sec_en_r};
        REG_HOPS: rdata_r <= {24'h00_0000, nh_r};
        REG_SLEEP: rdata_r <= {16'h0000, sp_r};
        REG_FCNT: rdata_r <= fcnt_r;
        REG_STAT: rdata_r <= {8'h00, tx_stat_r, rej_r, 6'h00, (t_st_r != T_IDLE), blocked};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // body bytes after the length field
  always_comb begin
    for (int i = 0; i < 8; i++) d64[63-8*i -: 8] = body[B_D64+i];
  end
  assign d16 = {body[B_D16], body[B_D16+1]};
  assign cmd = {body[B_CMD], body[B_CMD+1]};
  assign lcmd_ok = frame_ok_r && body[B_TYPE] == TYPE_LCMD && len_r >= LCMD_MIN_LEN;
  assign start_tx = frame_ok_r && body[B_TYPE] == TYPE_TXREQ && len_r >= TXREQ_MIN_LEN
                    && t_st_r == T_IDLE;

  // Local commands share the setting registers with the bus; the command wins a tie.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      sec_en_r <= 1'b0;
      ao_r <= 1'b0;
      key_new_r <= 1'b0;
      nh_r <= NH_RST;
      sp_r <= SP_RST;
    end else begin
      key_new_r <= wr_acc && I_AVS_ADDRESS == REG_CTRL && I_AVS_BYTEENABLE[0]
                   && I_AVS_WRITEDATA[CTRL_KEY_BIT];
      if (wr_acc && I_AVS_BYTEENABLE[0]) begin
        if (I_AVS_ADDRESS == REG_CTRL) begin
          sec_en_r <= I_AVS_WRITEDATA[CTRL_SEC_BIT];
          ao_r <= I_AVS_WRITEDATA[CTRL_AO_BIT];
        end
        if (I_AVS_ADDRESS == REG_HOPS) nh_r <= I_AVS_WRITEDATA[7:0];
        if (I_AVS_ADDRESS == REG_SLEEP) sp_r[7:0] <= I_AVS_WRITEDATA[7:0];
      end
      if (wr_acc && I_AVS_BYTEENABLE[1] && I_AVS_ADDRESS == REG_SLEEP)
        sp_r[15:8] <= I_AVS_WRITEDATA[15:8];
      if (lcmd_ok && cmd == CMD_AO) ao_r <= body[B_PARAM][0];
      if (lcmd_ok && cmd == CMD_NH) nh_r <= body[B_PARAM];
      if (lcmd_ok && cmd == CMD_SP && len_r >= SP_CMD_LEN)
        sp_r <= {body[B_PARAM], body[B_PARAM+1]};
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      p_st_r <= P_IDLE;
      len_r <= 16'h0000;
      cnt_r <= 16'h0000;
      sum_r <= 8'h00;
      frame_ok_r <= 1'b0;
      frame_bad_r <= 1'b0;
    end else begin
      frame_ok_r <= 1'b0;
      frame_bad_r <= 1'b0;
      if (I_API_RX_VALID) begin
        unique case (p_st_r)
          P_IDLE: if (I_API_RX_DATA == API_DELIM && !I_API_RX_LAST) p_st_r <= P_LENH;
          P_LENH: begin
            len_r[15:8] <= I_API_RX_DATA;
            frame_bad_r <= I_API_RX_LAST;
            p_st_r <= I_API_RX_LAST ? P_IDLE : P_LENL;
          end
          P_LENL: begin
            len_r[7:0] <= I_API_RX_DATA;
            cnt_r <= 16'h0000;
            sum_r <= 8'h00;
            if (I_API_RX_LAST || {len_r[15:8], I_API_RX_DATA} == 16'h0000
                || {len_r[15:8], I_API_RX_DATA} > 16'(MAXB)) begin
              frame_bad_r <= 1'b1;
              p_st_r <= P_IDLE;
            end else begin
              p_st_r <= P_BODY;
            end
          end
          P_BODY: begin
            cnt_r <= cnt_r + 16'h0001;
            sum_r <= sum_r + I_API_RX_DATA;
            if (I_API_RX_LAST) begin
              frame_bad_r <= 1'b1;
              p_st_r <= P_IDLE;
            end else if (cnt_r + 16'h0001 == len_r) begin
              p_st_r <= P_CSUM;
            end
          end
          P_CSUM: begin
            if (I_API_RX_LAST && I_API_RX_DATA == CSUM_BASE - sum_r) frame_ok_r <= 1'b1;
            else frame_bad_r <= 1'b1;
            p_st_r <= P_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_API_RX_VALID && p_st_r == P_BODY && cnt_r < 16'(MAXB))
      body[cnt_r[IW-1:0]] <= I_API_RX_DATA;
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) rej_r <= 8'h00;
    else if (frame_bad_r) rej_r <= rej_r + 8'h01;
  end

  assign tick = presc_r == '0;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || tick) presc_r <= ($clog2(CYC_PER_MS))'(CYC_PER_MS - 1);
    else presc_r <= presc_r - 1'b1;
  end

  assign blocked = sec_en_r && fcnt_r == FCNT_MAX;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      t_st_r <= T_IDLE;
      rfreq_r <= '0;
      ext_r <= 1'b0;
      fid_r <= 8'h00;
      tx_stat_r <= ST_OK;
      attempt_r <= 2'h0;
      send_r <= 1'b0;
      tmo_r <= 20'h0_0000;
    end else begin
      send_r <= 1'b0;
      if (t_st_r == T_WAIT && tick && tmo_r != 20'h0_0000) tmo_r <= tmo_r - 20'h0_0001;
      unique case (t_st_r)
        T_IDLE: if (start_tx) begin
          fid_r <= body[B_FID];
          attempt_r <= 2'h0;
          ext_r <= I_DST_END_DEV || body[B_OPT][OPT_EXT_BIT];
          rfreq_r.dst64 <= d64;
          rfreq_r.dst16 <= d16;
          rfreq_r.radius <= body[B_RAD] == 8'h00 ? NWK_MAX_RADIUS : body[B_RAD];
          rfreq_r.secure <= sec_en_r;
          rfreq_r.to_coord <= d64 == ADDR64_COORD && d16 == ADDR16_UNK;
          rfreq_r.bcast <= d64 == ADDR64_BCAST && d16 == ADDR16_UNK;
          rfreq_r.wake_sleepers <= d64 == ADDR64_BCAST && d16 == ADDR16_UNK;
          t_st_r <= T_SEND;
        end
        T_SEND: begin
          if (blocked && rfreq_r.secure) begin
            tx_stat_r <= ST_BLOCKED;
            t_st_r <= T_REPORT;
          end else begin
            send_r <= 1'b1;
            attempt_r <= attempt_r + 2'h1;
            // One extra ms keeps the wait at least the full timeout.
            tmo_r <= tmo_ms(nh_r, sp_r, ext_r) + 20'h0_0001;
            t_st_r <= T_WAIT;
          end
        end
        T_WAIT: begin
          if (I_RF_ACK) begin
            tx_stat_r <= ST_OK;
            t_st_r <= T_REPORT;
          end else if (tmo_r == 20'h0_0000) begin
            if (attempt_r == MAX_ATTEMPTS) begin
              tx_stat_r <= ST_NOACK;
              t_st_r <= T_REPORT;
            end else begin
              t_st_r <= T_SEND;
            end
          end
        end
        T_REPORT: if (!ser_busy_r) t_st_r <= T_IDLE;
      endcase
    end
  end

  assign O_RF_SEND = send_r;
  assign O_RF_REQ = rfreq_r;
  assign O_RF_FCNT = fcnt_r;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      ser_busy_r <= 1'b0;
      ser_idx_r <= 3'h0;
      ser_byte_r <= 8'h00;
    end else if (!ser_busy_r) begin
      if (t_st_r == T_REPORT && fid_r != 8'h00) begin
        ser_busy_r <= 1'b1;
        ser_idx_r <= 3'h0;
        ser_byte_r <= stat_byte(3'h0, fid_r, tx_stat_r);
      end
    end else if (I_API_TX_READY) begin
      ser_idx_r <= ser_idx_r + 3'h1;
      ser_byte_r <= stat_byte(ser_idx_r + 3'h1, fid_r, tx_stat_r);
      if (ser_idx_r == 3'h6) ser_busy_r <= 1'b0;
    end
  end

  assign O_API_TX_VALID = ser_busy_r;
  assign O_API_TX_DATA = ser_byte_r;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) fcnt_r <= 32'h0000_0000;
    else if (key_new_r) fcnt_r <= 32'h0000_0000;
    else if (send_r && rfreq_r.secure && fcnt_r != FCNT_MAX) fcnt_r <= fcnt_r + 32'h0000_0001;
  end

  assign rx_stale = I_RF_RX_SECURED && I_RF_RX_FCNT < nbr_cnt[I_RF_RX_NBR];
  assign rx_ok = !(I_RF_RX_SECURED && (!I_RF_RX_MIC_OK || rx_stale));

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || key_new_r) begin
      for (int i = 0; i < NBR; i++) nbr_cnt[i] <= 32'h0000_0000;
    end else if (I_RF_RX_VALID && I_RF_RX_SECURED && rx_ok) begin
      nbr_cnt[I_RF_RX_NBR] <= I_RF_RX_FCNT;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      deliver_r <= 1'b0;
      drop_r <= 1'b0;
      rx_type_r <= TYPE_RX;
    end else begin
      drop_r <= I_RF_RX_VALID && !rx_ok;
      deliver_r <= I_RF_RX_VALID && rx_ok && (!I_RF_RX_PROFILE || ao_r);
      if (I_RF_RX_VALID && rx_ok) rx_type_r <= ao_r ? TYPE_RXEXP : TYPE_RX;
    end
  end

  assign O_RX_DELIVER = deliver_r;
  assign O_RX_DROP = drop_r;
  assign O_RX_FRAME_TYPE = rx_type_r;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      hold_act_r <= 1'b0;
      hold_r <= 20'h0_0000;
      discard_r <= 1'b0;
    end else begin
      discard_r <= 1'b0;
      if (I_CHILD_HOLD_START) begin
        hold_act_r <= 1'b1;
        hold_r <= hold_ms(sp_r);
      end else if (I_CHILD_POLLED) begin
        hold_act_r <= 1'b0;
      end else if (hold_act_r && tick) begin
        hold_r <= hold_r - 20'h0_0001;
        if (hold_r <= 20'h0_0001) begin
          hold_act_r <= 1'b0;
          discard_r <= 1'b1;
        end
      end
    end
  end

  assign O_CHILD_DISCARD = discard_r;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) beacon_r <= 1'b0;
    else beacon_r <= I_MAC_BEACON_REQ;
  end
  assign O_MAC_BEACON_SEND = beacon_r;

  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  chk_fcnt_hold: assert property ((fcnt_r == FCNT_MAX && !key_new_r) |=> fcnt_r == FCNT_MAX)
    else $error("outgoing counter left saturation");
  chk_fcnt_step: assert property ((send_r && rfreq_r.secure && fcnt_r != FCNT_MAX && !key_new_r)
    |=> fcnt_r == $past(fcnt_r) + 32'h0000_0001)
    else $error("outgoing counter did not step");
  chk_key_clear: assert property (key_new_r |=> fcnt_r == 32'h0000_0000)
    else $error("counter not cleared on key change");
  chk_blocked_send: assert property (send_r |-> !(rfreq_r.secure && fcnt_r == FCNT_MAX))
    else $error("secured send while counter saturated");
  chk_replay_drop: assert property ((I_RF_RX_VALID && rx_stale) |=> O_RX_DROP && !O_RX_DELIVER)
    else $error("stale counter not dropped");
  chk_mic_drop: assert property ((I_RF_RX_VALID && I_RF_RX_SECURED && !I_RF_RX_MIC_OK)
    |=> O_RX_DROP && !O_RX_DELIVER)
    else $error("bad integrity code not dropped");
  chk_profile_gate: assert property ((I_RF_RX_VALID && I_RF_RX_PROFILE && !ao_r) |=> !O_RX_DELIVER)
    else $error("profile message delivered without addressing");
  chk_attempt_max: assert property (send_r |-> attempt_r inside {2'h1, 2'h2, 2'h3})
    else $error("attempt count out of range");
  chk_status_fid0: assert property ((t_st_r == T_REPORT && !ser_busy_r && fid_r == 8'h00)
    |=> !ser_busy_r [*2])
    else $error("status sent for zero identifier");
  chk_bad_frame: assert property ((I_API_RX_VALID && p_st_r == P_CSUM
    && I_API_RX_DATA != CSUM_BASE - sum_r) |=> frame_bad_r && !frame_ok_r)
    else $error("bad checksum accepted");
  chk_radius_nz: assert property (send_r |-> rfreq_r.radius != 8'h00)
    else $error("zero radius sent");

  cov_retry: cover property (send_r && attempt_r == 2'h3);
  cov_status: cover property (ser_busy_r && ser_idx_r == 3'h6 && I_API_TX_READY);
  cov_replay: cover property (I_RF_RX_VALID && rx_stale);
  cov_noack: cover property (t_st_r == T_REPORT && tx_stat_r == ST_NOACK);
endmodule

// File: tb/mtxfg_host_model.sv
// Host processor model that sends API frames and collects status bytes.
`timescale 1ns/1ps
module mtxfg_host_model (
  input wire logic clk,
  output logic o_valid,
  output logic [7:0] o_data,
  output logic o_last,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready
);
  logic [7:0] got_q[$];
  initial begin
    o_valid = 1'b0;
    o_data = 8'h00;
    o_last = 1'b0;
    o_tx_ready = 1'b0;
  end
  // Ready toggles so that the status path also meets back-pressure.
  always @(posedge clk) begin
    o_tx_ready <= ~o_tx_ready;
    if (i_tx_valid === 1'b1 && o_tx_ready) got_q.push_back(i_tx_data);
  end
  task automatic send(input logic [7:0] body[$], input logic bad);
    logic [7:0] s;
    logic [7:0] f[$];
    s = 8'h00;
    foreach (body[i]) s = s + body[i];
    f = {8'h7e, 8'h00, 8'(body.size()), body, (8'hff - s) ^ {7'h00, bad}};
    foreach (f[i]) begin
      @(posedge clk);
      o_valid <= 1'b1;
      o_data <= f[i];
      o_last <= (i == f.size() - 1);
    end
    @(posedge clk);
    o_valid <= 1'b0;
    o_last <= 1'b0;
    o_data <= ~f[f.size() - 1];
  endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the transmit framer and replay guard.
`timescale 1ns/1ps
module tb_top;
  import mtxfg_pkg::*;
  typedef logic [7:0] mtxfg_bq_t[$];
  logic I_CORE_CLK = 1'b0;
  logic I_RST = 1'b1;
  logic [4:0] I_AVS_ADDRESS = 5'h00;
  logic I_AVS_READ = 1'b0;
  logic I_AVS_WRITE = 1'b0;
  logic [31:0] I_AVS_WRITEDATA = 32'h0;
  logic I_DST_END_DEV = 1'b0;
  logic I_RF_ACK = 1'b0;
  logic I_RF_RX_VALID = 1'b0;
  logic I_RF_RX_PROFILE = 1'b0;
  logic I_RF_RX_SECURED = 1'b0;
  logic I_RF_RX_MIC_OK = 1'b0;
  logic [2:0] I_RF_RX_NBR = 3'h0;
  logic [31:0] I_RF_RX_FCNT = 32'h0;
  logic I_MAC_BEACON_REQ = 1'b0;
  logic I_CHILD_HOLD_START = 1'b0;
  logic I_CHILD_POLLED = 1'b0;
  logic rxv, rxl, txv, txr, snd, dlv, drp, wrq, bcn, dsc;
  logic [7:0] rxd, txd, ftype;
  logic [31:0] fcnt, fc_at, q, rdata;
  mtxfg_rfreq_s req;
  int err_total = 0, comparisons = 0, cyc = 0, nd = 0, nr = 0, nb = 0, hd = 0, h0 = 0;
  int t[$];
  logic [7:0] st_exp[7] = '{8'h7e, 8'h00, 8'h03, 8'h8b, 8'h01, 8'h01, 8'h72};
  always #4 I_CORE_CLK = ~I_CORE_CLK;
  always @(posedge I_CORE_CLK) begin
    cyc <= cyc + 1;
    // The header value is captured before the send is queued, so a waiter sees both.
    if (snd === 1'b1) fc_at = fcnt;
    if (snd === 1'b1) t.push_back(cyc);
    if (dlv === 1'b1) nd <= nd + 1;
    if (bcn === 1'b1) nb <= nb + 1;
    if (dsc === 1'b1) hd <= cyc;
    if (drp === 1'b1) nr <= nr + 1;
  end
  mtxfg_host_model host (.clk(I_CORE_CLK), .o_valid(rxv), .o_data(rxd), .o_last(rxl),
    .i_tx_valid(txv), .i_tx_data(txd), .o_tx_ready(txr));
  mtxfg_top #(.CYC_PER_MS(10)) dut (.I_CORE_CLK, .I_RST, .I_AVS_ADDRESS, .I_AVS_READ,
    .I_AVS_WRITE, .I_AVS_WRITEDATA, .I_AVS_BYTEENABLE(4'hf), .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(wrq), .I_API_RX_VALID(rxv), .I_API_RX_DATA(rxd), .I_API_RX_LAST(rxl),
    .O_API_TX_VALID(txv), .O_API_TX_DATA(txd), .I_API_TX_READY(txr), .I_DST_END_DEV,
    .O_RF_SEND(snd), .O_RF_REQ(req), .O_RF_FCNT(fcnt), .I_RF_ACK, .I_MAC_BEACON_REQ,
    .O_MAC_BEACON_SEND(bcn), .I_RF_RX_VALID, .I_RF_RX_PROFILE, .I_RF_RX_SECURED,
    .I_RF_RX_MIC_OK, .I_RF_RX_NBR, .I_RF_RX_FCNT, .O_RX_DELIVER(dlv), .O_RX_DROP(drp),
    .O_RX_FRAME_TYPE(ftype), .I_CHILD_HOLD_START, .I_CHILD_POLLED,
    .O_CHILD_DISCARD(dsc));
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic bail();
    err_total++;
    complete_run();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge I_CORE_CLK);
    I_AVS_ADDRESS <= a;
    I_AVS_WRITE <= wr;
    I_AVS_READ <= ~wr;
    I_AVS_WRITEDATA <= d;
    n = 0;
    do begin
      @(posedge I_CORE_CLK);
      n++;
    end while (wrq !== 1'b0 && n < 50);
    if (n >= 50) bail();
    q = rdata;
    I_AVS_READ <= 1'b0;
    I_AVS_WRITE <= 1'b0;
  endtask
  task automatic wsend(input int n);
    for (int k = 0; k < 20000 && t.size() < n; k++) @(posedge I_CORE_CLK);
    if (t.size() < n) bail();
  endtask
  task automatic wsts(input int n);
    // The no-ack status follows a whole further timeout, so the bound covers one.
    for (int k = 0; k < 2000 && host.got_q.size() < n; k++) @(posedge I_CORE_CLK);
    if (host.got_q.size() < n) bail();
  endtask
  task automatic gap(input int i, input int lo);
    chk("attempt gap", 1, 32'(t[i] - t[i-1] inside {[lo:lo+12]}));
  endtask
  task automatic ack();
    @(posedge I_CORE_CLK);
    I_RF_ACK <= 1'b1;
    @(posedge I_CORE_CLK);
    I_RF_ACK <= 1'b0;
  endtask
  task automatic rx(input logic s, m, p, input logic [31:0] f, input int ed, er);
    int d0, r0;
    d0 = nd;
    r0 = nr;
    @(posedge I_CORE_CLK);
    I_RF_RX_VALID <= 1'b1;
    I_RF_RX_SECURED <= s;
    I_RF_RX_MIC_OK <= m;
    I_RF_RX_PROFILE <= p;
    I_RF_RX_NBR <= 3'h2;
    I_RF_RX_FCNT <= f;
    @(posedge I_CORE_CLK);
    I_RF_RX_VALID <= 1'b0;
    repeat (3) @(posedge I_CORE_CLK);
    chk("delivered", ed, nd - d0);
    chk("dropped", er, nr - r0);
  endtask
  function automatic mtxfg_bq_t txreq(input logic [7:0] fid, input logic [63:0] d,
      input logic [15:0] s, input logic [7:0] r, input logic [7:0] o);
    mtxfg_bq_t b;
    b = {TYPE_TXREQ, fid};
    for (int i = 7; i >= 0; i--) b.push_back(d[i*8+:8]);
    b = {b, s[15:8], s[7:0], r, o, 8'h41};
    return b;
  endfunction
  initial begin
    repeat (16) @(posedge I_CORE_CLK);
    I_RST <= 1'b0;
    bus(0, REG_HOPS, 0);
    chk("hops reset", 32'h1e, q);
    bus(0, REG_SLEEP, 0);
    chk("sleep reset", 32'h20, q);
    bus(0, 5'h14, 0);
    chk("unmapped", 0, q);
    bus(1, REG_HOPS, 1);
    // Unacknowledged unicast: three attempts, then a no-ack status frame.
    host.send(txreq(1, ADDR64_COORD, ADDR16_UNK, 0, 0), 0);
    wsend(3);
    gap(1, 1500);
    gap(2, 1500);
    chk("to coordinator", 1, req.to_coord);
    chk("radius", NWK_MAX_RADIUS, req.radius);
    wsts(7);
    foreach (st_exp[i]) chk("status byte", st_exp[i], host.got_q[i]);
    repeat (1600) @(posedge I_CORE_CLK);
    chk("attempts", 3, t.size());
    host.send(txreq(2, 64'h1234, 16'h1234, 5, 8'h40), 0);
    wsend(5);
    gap(4, 4340);
    chk("radius", 5, req.radius);
    chk("dest16", 32'h1234, req.dst16);
    chk("dest64 low", 32'h1234, req.dst64[31:0]);
    ack();
    wsts(14);
    chk("ack status", ST_OK, host.got_q[12]);
    host.send(txreq(0, ADDR64_BCAST, ADDR16_UNK, 0, 0), 0);
    wsend(6);
    chk("broadcast", 2'b11, {req.bcast, req.wake_sleepers});
    ack();
    repeat (100) @(posedge I_CORE_CLK);
    chk("no status", 14, host.got_q.size());
    host.send(txreq(0, 64'h1, 16'h1, 0, 0), 1);
    bus(0, REG_STAT, 0);
    chk("rejects", 1, q[15:8]);
    chk("no send", 6, t.size());
    bus(1, REG_CTRL, 1);
    host.send(txreq(0, 64'h1234, 16'h1234, 0, 0), 0);
    wsend(7);
    chk("secure", 1, req.secure);
    chk("header count", 0, fc_at);
    ack();
    bus(0, REG_FCNT, 0);
    chk("count", 1, q);
    rx(1, 1, 0, 5, 1, 0);
    rx(1, 1, 0, 3, 0, 1);
    rx(1, 0, 0, 6, 0, 1);
    rx(0, 1, 1, 0, 0, 0);
    bus(1, REG_CTRL, 5);
    bus(0, REG_FCNT, 0);
    chk("count cleared", 0, q);
    rx(1, 1, 0, 3, 1, 0);
    host.send({TYPE_LCMD, 8'h01, 8'h41, 8'h4f, 8'h01}, 0);
    rx(0, 1, 0, 0, 1, 0);
    chk("explicit type", TYPE_RXEXP, ftype);
    rx(0, 1, 1, 0, 1, 0);
    // Sleep setting 0x20 units is 320 ms, so the hold is 384 ms, 3840 cycles.
    @(posedge I_CORE_CLK);
    I_MAC_BEACON_REQ <= 1'b1;
    I_CHILD_HOLD_START <= 1'b1;
    h0 = cyc;
    @(posedge I_CORE_CLK);
    I_MAC_BEACON_REQ <= 1'b0;
    I_CHILD_HOLD_START <= 1'b0;
    repeat (3900) @(posedge I_CORE_CLK);
    chk("beacons", 1, nb);
    chk("hold limit", 1, 32'(hd - h0 inside {[3830:3845]}));
    h0 = hd;
    I_CHILD_HOLD_START <= 1'b1;
    @(posedge I_CORE_CLK);
    I_CHILD_HOLD_START <= 1'b0;
    I_CHILD_POLLED <= 1'b1;
    @(posedge I_CORE_CLK);
    I_CHILD_POLLED <= 1'b0;
    repeat (3900) @(posedge I_CORE_CLK);
    chk("polled keeps", h0, hd);
    complete_run();
  end
endmodule
